// File: hw/bms_boot_sel.sv
/*
  Reset-time boot source decision: program pin, jump fuse, user vector.
  Assumes pin and fuse are stable around reset release.
*/
`include "bms_cfg.svh"
module bms_boot_sel
  import bms_pkg::*;
(
  input  wire logic        program_mode_pin_n_i,
  input  wire logic        bootloader_jump_fuse_i,
  input  wire logic        use_user_vector_i,
  input  wire logic [7:0]  user_boot_vector_i,
  output bms_pkg::bms_boot_t boot_o
);
  import bms_pkg::*;

  // ----------------------------------------
  // Decision
  // ----------------------------------------
  // Fuse is active low: programmed reads as 0
  wire to_boot = !program_mode_pin_n_i || !bootloader_jump_fuse_i; // R11 R12

  assign boot_o.boot_mapped  = to_boot;                            // R11 R12
  assign boot_o.reset_vector = to_boot ? `BMS_VEC_BOOT :           // R11 R12
                               use_user_vector_i ? {user_boot_vector_i, `BMS_VEC_LOW} : // R8
                               `BMS_VEC_APP;                       // R16
endmodule // bms_boot_sel

// File: hw/bms_cfg.svh
/*
  Constants for the boot map and flash security block: register offset, field
  positions, security encodings and vectors.
  Assumes inclusion by bare name from the package and design modules.
*/
`ifndef BMS_CFG_SVH
`define BMS_CFG_SVH

// ----------------------------------------
// Auxiliary control register
// ----------------------------------------
`define BMS_AUX_OFFSET      8'ha2
`define BMS_AUX_DPS_BIT     0
`define BMS_AUX_ZERO_BIT    2
`define BMS_AUX_GF_BIT      3
`define BMS_AUX_BOOT_BIT    5
`define BMS_AUX_RESET       8'h00

// ----------------------------------------
// Security level encodings
// ----------------------------------------
`define BMS_SEC_NONE        8'hff
`define BMS_SEC_WRITE       8'hfe
`define BMS_SEC_RDWR        8'hfc

// ----------------------------------------
// Vectors and boot window
// ----------------------------------------
`define BMS_VEC_APP         16'h0000
`define BMS_VEC_BOOT        16'hf000
`define BMS_BOOT_BASE_HI    4'hf
`define BMS_VEC_LOW         8'h00

`endif

// File: hw/bms_pkg.sv
/*
  Types for the boot map and flash security block.
  Assumes bms_cfg.svh is on the include path.
*/
package bms_pkg;
  `include "bms_cfg.svh"

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    BMS_LVL0,
    BMS_LVL1,
    BMS_LVL2
  } bms_level_t;

  typedef enum logic [3:0] {
    BMS_OP_FLASH_RD,
    BMS_OP_FLASH_WR,
    BMS_OP_FUSE_RD,
    BMS_OP_FUSE_WR,
    BMS_OP_CFG_RD,
    BMS_OP_CFG_WR,
    BMS_OP_SEC_RD,
    BMS_OP_SEC_WR,
    BMS_OP_INFO_RD,
    BMS_OP_INFO_WR,
    BMS_OP_BLOCK_ERASE,
    BMS_OP_CHIP_ERASE,
    BMS_OP_BLANK_CHECK
  } bms_op_t;

  typedef enum logic [1:0] {
    BMS_ST_OK,
    BMS_ST_ERR_WRITE,
    BMS_ST_VENDOR_ERROR_STATUS
  } bms_status_t;

  typedef struct packed {
    bms_op_t    op;
    logic [7:0] data;
  } bms_req_t;

  typedef struct packed {
    logic        allow;
    bms_status_t status;
  } bms_rsp_t;

  typedef struct packed {
    logic [15:0] reset_vector;
    logic        boot_mapped;
  } bms_boot_t;
endpackage

// File: hw/bms_sec_check.sv
/*
  Combinational access check of one programming request against the current
  security level.
  Assumes the level is held stable by the caller while the request is valid.
*/
`include "bms_cfg.svh"
module bms_sec_check
  import bms_pkg::*;
(
  input  bms_pkg::bms_level_t level_i,
  input  bms_pkg::bms_req_t   req_i,
  output bms_pkg::bms_rsp_t   rsp_o
);
  import bms_pkg::*;

  // ----------------------------------------
  // Permission table
  // ----------------------------------------
  wire sec_target_ok = (req_i.data == `BMS_SEC_WRITE) || (req_i.data == `BMS_SEC_RDWR); // R17
  wire sec_raise_ok  = (level_i == BMS_LVL0) ? sec_target_ok :
                       (level_i == BMS_LVL1) ? (req_i.data == `BMS_SEC_RDWR) : 1'b0;   // R2

  logic allow;
  always_comb begin
    case (req_i.op)
      BMS_OP_FLASH_RD:    allow = (level_i != BMS_LVL2);        // R3 R4
      BMS_OP_FLASH_WR:    allow = (level_i == BMS_LVL0);        // R3 R4
      BMS_OP_FUSE_RD:     allow = (level_i != BMS_LVL2);        // R6
      BMS_OP_FUSE_WR:     allow = (level_i == BMS_LVL0);        // R6
      BMS_OP_CFG_RD:      allow = 1'b1;
      BMS_OP_CFG_WR:      allow = 1'b1;
      BMS_OP_SEC_RD:      allow = 1'b1;
      BMS_OP_SEC_WR:      allow = sec_raise_ok;                 // R2
      BMS_OP_INFO_RD:     allow = 1'b1;                         // R7
      BMS_OP_INFO_WR:     allow = 1'b0;                         // R7
      BMS_OP_BLOCK_ERASE: allow = (level_i == BMS_LVL0);
      BMS_OP_CHIP_ERASE:  allow = 1'b1;                         // R5
      BMS_OP_BLANK_CHECK: allow = 1'b1;
      default:            allow = 1'b0;
    endcase
  end

  // Level 2 flash reads report vendor error, writes report write error
  assign rsp_o.allow  = allow;
  assign rsp_o.status = allow ? BMS_ST_OK :
                        ((req_i.op == BMS_OP_FLASH_RD) || (req_i.op == BMS_OP_FUSE_RD)) ?
                        BMS_ST_VENDOR_ERROR_STATUS : BMS_ST_ERR_WRITE;   // R3 R4
endmodule // bms_sec_check

// File: hw/bms_top.sv
/*
  Boot map and flash security block: auxiliary control register, security
  level store, programming access checks and reset boot decision.
  Assumes a processor special-register port with one-cycle read and write
  strobes, and a programming request port with valid pulses.
*/
// What this block does
// R1 - The security byte encodes no security as ffh, write protect as feh and read-write protect as fch.
// R2 - A security write is accepted only if it raises protection: level 0 to 1 or 2, level 1 to 2.
// R3 - At level 1 flash writes are refused with write error while reads pass.
// R4 - At level 2 flash reads and writes are refused with write or vendor error.
// R5 - Only a full chip erase returns the level to none, and chip erase is allowed at every level.
// R6 - Fuse accesses are free at level 0, read only at level 1, refused at level 2.
// R7 - Manufacturer and bootloader information are readable and never writable.
// R8 - The user bootloader starts at user vector high byte with low byte 00h in application flash.
// R9 - While the boot map bit 5 is set the boot flash occupies f000h to ffffh.
// R10 - Software may set the boot map bit by writing the auxiliary register.
// R11 - A low program pin at reset sets the boot map bit and vectors to f000h.
// R12 - A programmed jump fuse at reset sets the boot map bit and vectors to f000h.
// R13 - Bit 2 of the auxiliary register reads 0 and ignores writes.
// R14 - Bit 3 of the auxiliary register is a free user flag.
// R15 - Software never writes 1 to reserved bits 7-6 and 4.
// R16 - With fuse unprogrammed and pin high, reset starts the application at 0000h, or at the user vector when use_user_vector_i is set.
// R17 - A security value other than the three encodings is rejected and the level kept.
`include "bms_cfg.svh"
module bms_top
  import bms_pkg::*;
#(
  parameter logic [7:0] SEC_INIT = `BMS_SEC_NONE
) (
  input  wire logic          core_clk_i,
  input  wire logic          rstn_i,
  // Special register port
  input  wire logic          sfr_wr_i,
  input  wire logic          sfr_rd_i,
  input  wire logic [7:0]    sfr_addr_i,
  input  wire logic [7:0]    sfr_wdata_i,
  output logic      [7:0]    sfr_rdata_o,
  output logic               sfr_hit_o,
  // Programming requests
  input  wire logic          req_valid_i,
  input  bms_pkg::bms_req_t  req_i,
  output logic               rsp_valid_o,
  output bms_pkg::bms_rsp_t  rsp_o,
  output logic      [7:0]    security_level_byte_o,
  // Boot inputs
  input  wire logic          program_mode_pin_n_i,
  input  wire logic          bootloader_jump_fuse_i,
  input  wire logic          use_user_vector_i,
  input  wire logic [7:0]    user_boot_vector_i,
  // Boot and auxiliary outputs, code address decode
  output logic      [15:0]   reset_vector_o,
  output logic               boot_flash_mapped_o,
  output logic               data_pointer_select_o,
  input  wire logic [15:0]   code_addr_i,
  output logic               code_in_boot_o
);
  import bms_pkg::*;

  // ----------------------------------------
  // Reset release capture
  // ----------------------------------------
  // Straps are sampled on the first clock after release, never under reset
  logic       init_done_q;
  bms_boot_t  boot_sel;
  bms_boot_t  boot_q;

  bms_boot_sel u_boot_sel (
    .program_mode_pin_n_i   (program_mode_pin_n_i),
    .bootloader_jump_fuse_i (bootloader_jump_fuse_i),
    .use_user_vector_i      (use_user_vector_i),
    .user_boot_vector_i     (user_boot_vector_i),
    .boot_o                 (boot_sel)
  );

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      init_done_q <= 1'b0;
      boot_q      <= '0;
    end else if (!init_done_q) begin
      init_done_q <= 1'b1;
      boot_q      <= boot_sel;                                     // R11 R12 R16 R8
    end
  end

  // ----------------------------------------
  // Auxiliary control register
  // ----------------------------------------
  wire aux_sel = (sfr_addr_i == `BMS_AUX_OFFSET);
  wire aux_wr  = sfr_wr_i && aux_sel;

  logic boot_map_enable_q;
  logic general_user_flag_q;
  logic data_pointer_select_q;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_map_enable_q     <= 1'b0;
      general_user_flag_q   <= 1'b0;
      data_pointer_select_q <= 1'b0;
    end else if (!init_done_q) begin
      boot_map_enable_q     <= boot_sel.boot_mapped;               // R11 R12
    end else if (aux_wr) begin
      boot_map_enable_q     <= sfr_wdata_i[`BMS_AUX_BOOT_BIT];     // R9 R10
      general_user_flag_q   <= sfr_wdata_i[`BMS_AUX_GF_BIT];       // R14
      data_pointer_select_q <= sfr_wdata_i[`BMS_AUX_DPS_BIT];
    end
  end

  // Reserved bits read as zero; bit 2 is hard zero so an increment flips only bit 0
  wire [7:0] aux_read = {2'b00, boot_map_enable_q, 1'b0, general_user_flag_q,
                         1'b0, 1'b0, data_pointer_select_q};       // R13

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= `BMS_AUX_RESET;
    end else begin
      sfr_rdata_o <= (sfr_rd_i && aux_sel) ? aux_read : 8'h00;
    end
  end

  assign sfr_hit_o             = aux_sel && (sfr_rd_i || sfr_wr_i);
  assign boot_flash_mapped_o   = boot_map_enable_q;
  assign data_pointer_select_o = data_pointer_select_q;
  assign reset_vector_o        = boot_q.reset_vector;
  assign code_in_boot_o        = boot_map_enable_q &&
                                 (code_addr_i[15:12] == `BMS_BOOT_BASE_HI); // R9

  // ----------------------------------------
  // Security level
  // ----------------------------------------
  logic [7:0] sec_q;
  bms_level_t level;
  bms_rsp_t   chk;

  assign level = (sec_q == `BMS_SEC_NONE)  ? BMS_LVL0 :
                 (sec_q == `BMS_SEC_WRITE) ? BMS_LVL1 : BMS_LVL2;  // R1

  bms_sec_check u_sec_check (
    .level_i (level),
    .req_i   (req_i),
    .rsp_o   (chk)
  );

  wire sec_write = req_valid_i && chk.allow && (req_i.op == BMS_OP_SEC_WR);
  wire chip_erase = req_valid_i && (req_i.op == BMS_OP_CHIP_ERASE);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sec_q       <= SEC_INIT;
      rsp_valid_o <= 1'b0;
      rsp_o       <= '0;
    end else begin
      if (chip_erase) begin
        sec_q <= `BMS_SEC_NONE;                                    // R5
      end else if (sec_write) begin
        sec_q <= req_i.data;                                       // R2 R17
      end
      rsp_valid_o <= req_valid_i;
      if (req_valid_i) begin
        rsp_o <= chk;                                              // R3 R4 R6 R7
      end
    end
  end

  assign security_level_byte_o = sec_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence flash_wr_at_l1_s;
    req_valid_i && (req_i.op == BMS_OP_FLASH_WR) && (level == BMS_LVL1);
  endsequence

  sequence flash_rd_at_l1_s;
    req_valid_i && (req_i.op == BMS_OP_FLASH_RD) && (level == BMS_LVL1);
  endsequence

  sequence flash_rd_at_l2_s;
    req_valid_i && (req_i.op == BMS_OP_FLASH_RD) && (level == BMS_LVL2);
  endsequence

  sequence l0_to_l1_s;
    req_valid_i && (req_i.op == BMS_OP_SEC_WR) && (level == BMS_LVL0) && (req_i.data == `BMS_SEC_WRITE);
  endsequence

  sequence l1_to_l2_s;
    req_valid_i && (req_i.op == BMS_OP_SEC_WR) && (level == BMS_LVL1) && (req_i.data == `BMS_SEC_RDWR);
  endsequence

  sequence bad_sec_value_s;
    req_valid_i && (req_i.op == BMS_OP_SEC_WR) && (req_i.data != `BMS_SEC_WRITE) && (req_i.data != `BMS_SEC_RDWR);
  endsequence

  sequence aux_write_s;
    init_done_q && aux_wr;
  endsequence

  sequence aux_read_s;
    sfr_rd_i && aux_sel;
  endsequence

  sec_encoding_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R1 R17
    (sec_q == `BMS_SEC_NONE) || (sec_q == `BMS_SEC_WRITE) || (sec_q == `BMS_SEC_RDWR))
    else $error("security byte left the defined encodings"); // R1 R17

  sec_raise_only_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R2
    !$past(chip_erase) |-> (sec_q <= $past(sec_q)))
    else $error("security level lowered without chip erase"); // R2

  l1_write_refused_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R3
    flash_wr_at_l1_s |=> rsp_valid_o && !rsp_o.allow && (rsp_o.status == BMS_ST_ERR_WRITE))
    else $error("flash write passed at level 1"); // R3

  l2_access_refused_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R4
    req_valid_i && (level == BMS_LVL2) &&
    ((req_i.op == BMS_OP_FLASH_RD) || (req_i.op == BMS_OP_FLASH_WR)) |=> !rsp_o.allow)
    else $error("flash access passed at level 2"); // R4

  chip_erase_clears_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R5
    chip_erase |=> (sec_q == `BMS_SEC_NONE) && rsp_o.allow)
    else $error("chip erase did not clear security"); // R5

  fuse_rules_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R6
    req_valid_i && (req_i.op == BMS_OP_FUSE_WR) && (level != BMS_LVL0) |=> !rsp_o.allow)
    else $error("fuse write passed above level 0"); // R6

  info_readonly_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R7
    req_valid_i && (req_i.op == BMS_OP_INFO_WR) |=> rsp_valid_o && !rsp_o.allow)
    else $error("information write accepted"); // R7

  strap_boot_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R11 R12
    !init_done_q && (!program_mode_pin_n_i || !bootloader_jump_fuse_i) |=>
    boot_map_enable_q && (reset_vector_o == `BMS_VEC_BOOT))
    else $error("strap did not select boot flash"); // R11 R12

  app_boot_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R16
    !init_done_q && program_mode_pin_n_i && bootloader_jump_fuse_i && !use_user_vector_i |=>
    !boot_map_enable_q && (reset_vector_o == `BMS_VEC_APP))
    else $error("application vector wrong"); // R16

  user_vector_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R8
    !init_done_q && program_mode_pin_n_i && bootloader_jump_fuse_i && use_user_vector_i |=>
    (reset_vector_o == {$past(user_boot_vector_i), `BMS_VEC_LOW}))
    else $error("user boot vector wrong"); // R8

  boot_window_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R9
    code_in_boot_o |-> boot_map_enable_q && (code_addr_i >= `BMS_VEC_BOOT))
    else $error("boot window decode wrong"); // R9

  aux_zero_bit_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R13
    $past(sfr_rd_i && aux_sel) |-> !sfr_rdata_o[`BMS_AUX_ZERO_BIT])
    else $error("stuck zero bit read as one"); // R13

  gf_write_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R14
    init_done_q && aux_wr |=> general_user_flag_q == $past(sfr_wdata_i[`BMS_AUX_GF_BIT]))
    else $error("general flag not written"); // R14

  l1_read_passes_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R3
    flash_rd_at_l1_s |=> rsp_valid_o && rsp_o.allow && (rsp_o.status == BMS_ST_OK))
    else $error("flash read refused at level 1");

  l2_read_status_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R4
    flash_rd_at_l2_s |=> !rsp_o.allow && (rsp_o.status != BMS_ST_OK))
    else $error("level 2 read answered without error");

  l0_raise_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R2
    l0_to_l1_s |=> rsp_o.allow && (sec_q == `BMS_SEC_WRITE))
    else $error("raise from level 0 refused");

  l1_raise_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R2
    l1_to_l2_s |=> rsp_o.allow && (sec_q == `BMS_SEC_RDWR))
    else $error("raise from level 1 refused");

  sec_bad_value_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R17
    bad_sec_value_s |=> !rsp_o.allow && $stable(sec_q))
    else $error("undefined security value accepted");

  fuse_read_l1_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R6
    req_valid_i && (req_i.op == BMS_OP_FUSE_RD) && (level == BMS_LVL1) |=> rsp_o.allow)
    else $error("fuse read refused at level 1");

  fuse_l2_refused_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R6
    req_valid_i && (level == BMS_LVL2) &&
    ((req_i.op == BMS_OP_FUSE_RD) || (req_i.op == BMS_OP_FUSE_WR)) |=> !rsp_o.allow)
    else $error("fuse access passed at level 2");

  info_read_ok_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R7
    req_valid_i && (req_i.op == BMS_OP_INFO_RD) |=> rsp_valid_o && rsp_o.allow)
    else $error("information read refused");

  map_write_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R9 R10
    aux_write_s |=> boot_flash_mapped_o == $past(sfr_wdata_i[`BMS_AUX_BOOT_BIT]))
    else $error("boot map bit not written");

  map_hold_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R9
    init_done_q && !aux_wr |=> $stable(boot_map_enable_q))
    else $error("boot map bit changed without write");

  window_hit_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R9
    boot_flash_mapped_o && (code_addr_i >= `BMS_VEC_BOOT) |-> code_in_boot_o)
    else $error("boot window missed");

  gf_readback_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R14
    aux_read_s |=> sfr_rdata_o[`BMS_AUX_GF_BIT] == $past(general_user_flag_q))
    else $error("general flag read back wrong");

  gf_hold_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R14
    init_done_q && !aux_wr |=> $stable(general_user_flag_q))
    else $error("general flag changed without write");

  vector_hold_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // R11 R12 R16
    init_done_q |=> $stable(reset_vector_o))
    else $error("reset vector changed after start");

  rsp_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    req_valid_i |=> rsp_valid_o)
    else $error("request not answered");
endmodule // bms_top

// File: tb/bms_host_model.sv
/*
  Partner model: programming host and processor firmware. It drives the special
  register port and the programming request port through tasks.
  Assumes a free-running core clock and calls from the bench top.
*/
module bms_host_model
  import bms_pkg::*;
(
  input  wire logic       core_clk_i,
  output logic            sfr_wr_o,
  output logic            sfr_rd_o,
  output logic [7:0]      sfr_addr_o,
  output logic [7:0]      sfr_wdata_o,
  output logic            req_valid_o,
  output bms_pkg::bms_req_t req_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_addr_o = 8'h00;
    sfr_wdata_o = 8'h00;
    req_valid_o = 1'b0;
    req_o = '{op: BMS_OP_BLANK_CHECK, data: 8'h00};
  end

  // ----------------------------------------
  // Register access, one strobe cycle
  // ----------------------------------------
  // Reserved bits are masked so firmware never sets them
  task automatic sfr_acc(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    @(posedge core_clk_i);
    #1;
    sfr_wr_o = wr;
    sfr_rd_o = ~wr;
    sfr_addr_o = addr;
    sfr_wdata_o = wd & 8'h2f;
    @(posedge core_clk_i);
    #1;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_addr_o = ~addr;
    sfr_wdata_o = ~sfr_wdata_o;
  endtask

  // ----------------------------------------
  // Programming request, one valid pulse
  // ----------------------------------------
  task automatic req_send(input bms_op_t op, input logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    req_valid_o = 1'b1;
    req_o = '{op: op, data: d};
    @(posedge core_clk_i);
    #1;
    req_valid_o = 1'b0;
    req_o.data = ~d;
  endtask
endmodule // bms_host_model

// File: tb/bms_top_tb.sv
/*
  Self-checking bench for the boot map and flash security block.
  Assumes the host model drives both request ports; straps are set here.
*/
module bms_top_tb
  import bms_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    bms_op_t     op;
    logic [7:0]  d;
    logic        allow;
    bms_status_t st;
    logic [7:0]  lvl;
  } bms_step_t;

  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        sfr_wr, sfr_rd, sfr_hit, req_valid, rsp_valid;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, sec_byte, uv = 8'h00;
  bms_req_t    req;
  bms_rsp_t    rsp;
  logic        pin_n = 1'b1, fuse = 1'b1, use_uv = 1'b0, mapped, data_pointer_select, in_boot;
  logic [15:0] rvec, code_addr = 16'h0000;
  int          n_fail = 0;
  int          tests_run = 0;
  logic        hit_q;

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) hit_q <= sfr_hit;

  bms_host_model host (.core_clk_i(core_clk), .sfr_wr_o(sfr_wr), .sfr_rd_o(sfr_rd), .sfr_addr_o(sfr_addr),
    .sfr_wdata_o(sfr_wdata), .req_valid_o(req_valid), .req_o(req));

  bms_top dut (.core_clk_i(core_clk), .rstn_i(rstn), .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd),
    .sfr_addr_i(sfr_addr), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata), .sfr_hit_o(sfr_hit),
    .req_valid_i(req_valid), .req_i(req), .rsp_valid_o(rsp_valid), .rsp_o(rsp),
    .security_level_byte_o(sec_byte), .program_mode_pin_n_i(pin_n), .bootloader_jump_fuse_i(fuse),
    .use_user_vector_i(use_uv), .user_boot_vector_i(uv), .reset_vector_o(rvec),
    .boot_flash_mapped_o(mapped), .data_pointer_select_o(data_pointer_select), .code_addr_i(code_addr),
    .code_in_boot_o(in_boot));

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rsp(input logic allow, input bms_status_t st);
    tests_run++;
    if (rsp_valid !== 1'b1 || rsp.allow !== allow || rsp.status !== st) begin
      n_fail++;
      $display("[FAIL] %0t response %b %b exp %b %b", $time, rsp_valid, rsp, allow, st);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Straps are applied during reset; outputs settle on the first edge after release
  task automatic do_reset(input logic p, input logic f, input logic u, input logic [7:0] v);
    rstn = 1'b0;
    pin_n = p;
    fuse = f;
    use_uv = u;
    uv = v;
    repeat (2) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_boot;
    do_reset(1'b1, 1'b1, 1'b0, 8'h5a);
    chk(rvec, 16'h0000, "app vector");
    chk({15'h0, mapped}, 16'h0, "app unmapped");
    chk({8'h0, sec_byte}, 16'h00ff, "level after reset");
    do_reset(1'b0, 1'b1, 1'b1, 8'h5a);
    chk({rvec[15:1], mapped}, 16'hf001, "pin boot");
    do_reset(1'b1, 1'b0, 1'b1, 8'h5a);
    chk({rvec[15:1], mapped}, 16'hf001, "fuse boot");
    do_reset(1'b1, 1'b1, 1'b1, 8'h5a);
    chk({rvec[15:1], mapped}, 16'h5a00, "user vector");
    pin_n = 1'b0;
    fuse = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk({rvec[15:1], mapped}, 16'h5a00, "straps ignored after start");
    pin_n = 1'b1;
    fuse = 1'b1;
  endtask

  task automatic t_aux;
    host.sfr_acc(1'b1, 8'ha2, 8'h28);
    chk({15'h0, mapped}, 16'h1, "map set");
    chk({15'h0, hit_q}, 16'h1, "hit on write");
    code_addr = 16'hf000;
    #1;
    chk({15'h0, in_boot}, 16'h1, "f000 in boot");
    code_addr = 16'hefff;
    #1;
    chk({15'h0, in_boot}, 16'h0, "efff outside");
    host.sfr_acc(1'b0, 8'ha2, 8'h00);
    chk({8'h0, sfr_rdata}, 16'h0028, "flag readback");
    chk({15'h0, hit_q}, 16'h1, "hit on read");
    host.sfr_acc(1'b1, 8'ha2, 8'h0d);
    host.sfr_acc(1'b0, 8'ha2, 8'h00);
    chk({8'h0, sfr_rdata}, 16'h0009, "zero bit");
    chk({14'h0, data_pointer_select, mapped}, 16'h2, "select set, map cleared");
    host.sfr_acc(1'b1, 8'ha3, 8'h28);
    code_addr = 16'hffff;
    #1;
    chk({14'h0, mapped, in_boot}, 16'h0, "other address ignored");
    host.sfr_acc(1'b0, 8'ha3, 8'h00);
    chk({8'h0, sfr_rdata}, 16'h0000, "other address reads zero");
    chk({15'h0, hit_q}, 16'h0, "no hit on other address");
  endtask

  task automatic t_security;
    bms_step_t steps [27];
    steps = '{
      '{BMS_OP_FLASH_WR, 8'h00, 1'b1, BMS_ST_OK, 8'hff},
      '{BMS_OP_FUSE_WR, 8'h00, 1'b1, BMS_ST_OK, 8'hff},
      '{BMS_OP_BLOCK_ERASE, 8'h00, 1'b1, BMS_ST_OK, 8'hff},
      '{BMS_OP_CFG_WR, 8'h00, 1'b1, BMS_ST_OK, 8'hff},
      '{BMS_OP_SEC_WR, 8'h55, 1'b0, BMS_ST_ERR_WRITE, 8'hff},
      '{BMS_OP_SEC_WR, 8'hfe, 1'b1, BMS_ST_OK, 8'hfe},
      '{BMS_OP_FLASH_WR, 8'h00, 1'b0, BMS_ST_ERR_WRITE, 8'hfe},
      '{BMS_OP_FLASH_RD, 8'h00, 1'b1, BMS_ST_OK, 8'hfe},
      '{BMS_OP_FUSE_WR, 8'h00, 1'b0, BMS_ST_ERR_WRITE, 8'hfe},
      '{BMS_OP_FUSE_RD, 8'h00, 1'b1, BMS_ST_OK, 8'hfe},
      '{BMS_OP_BLOCK_ERASE, 8'h00, 1'b0, BMS_ST_ERR_WRITE, 8'hfe},
      '{BMS_OP_CFG_WR, 8'h00, 1'b1, BMS_ST_OK, 8'hfe},
      '{BMS_OP_SEC_RD, 8'h00, 1'b1, BMS_ST_OK, 8'hfe},
      '{BMS_OP_SEC_WR, 8'hff, 1'b0, BMS_ST_ERR_WRITE, 8'hfe},
      '{BMS_OP_SEC_WR, 8'hfc, 1'b1, BMS_ST_OK, 8'hfc},
      '{BMS_OP_FLASH_RD, 8'h00, 1'b0, BMS_ST_VENDOR_ERROR_STATUS, 8'hfc},
      '{BMS_OP_FLASH_WR, 8'h00, 1'b0, BMS_ST_ERR_WRITE, 8'hfc},
      '{BMS_OP_FUSE_RD, 8'h00, 1'b0, BMS_ST_VENDOR_ERROR_STATUS, 8'hfc},
      '{BMS_OP_INFO_RD, 8'h00, 1'b1, BMS_ST_OK, 8'hfc},
      '{BMS_OP_INFO_WR, 8'h00, 1'b0, BMS_ST_ERR_WRITE, 8'hfc},
      '{BMS_OP_FUSE_WR, 8'h00, 1'b0, BMS_ST_ERR_WRITE, 8'hfc},
      '{BMS_OP_BLANK_CHECK, 8'h00, 1'b1, BMS_ST_OK, 8'hfc},
      '{BMS_OP_CFG_RD, 8'h00, 1'b1, BMS_ST_OK, 8'hfc},
      '{BMS_OP_SEC_WR, 8'hfe, 1'b0, BMS_ST_ERR_WRITE, 8'hfc},
      '{BMS_OP_CHIP_ERASE, 8'h00, 1'b1, BMS_ST_OK, 8'hff},
      '{BMS_OP_SEC_WR, 8'hfc, 1'b1, BMS_ST_OK, 8'hfc},
      '{BMS_OP_CHIP_ERASE, 8'h00, 1'b1, BMS_ST_OK, 8'hff}};
    foreach (steps[i]) begin
      host.req_send(steps[i].op, steps[i].d);
      chk_rsp(steps[i].allow, steps[i].st);
      chk({8'h0, sec_byte}, {8'h0, steps[i].lvl}, "level");
    end
    @(posedge core_clk);
    #1;
    chk({15'h0, rsp_valid}, 16'h0, "response pulse ends");
    chk({13'h0, rsp}, {13'h0, 1'b1, BMS_ST_OK}, "response held");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    t_boot();
    t_aux();
    t_security();
    tally_and_finish();
  end

  initial begin
    #500000;
    n_fail++;
    tally_and_finish();
  end
endmodule // bms_top_tb
